// ---- bench/itm_props.sv ----
/*
  Assertion checker for itm_top, bound to every instance.
  Assumes only the top module's ports; i_hready is the slave's own hreadyout.
*/
module itm_props (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic i_hsel,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic i_hready,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire logic i_sub_clk,
  input wire logic i_low_speed_oscillator_clk,
  input wire logic i_standby,
  input wire logic o_periph_sub_clk_en,
  input wire logic o_interval_timer_irq,
  input wire logic o_irq
);
  logic take;
  logic wr_dp_ff;
  assign take = i_hsel && i_hready && i_ce && i_htrans == itm_pkg::HTRANS_NONSEQ;
  // Marks the data phase of a write, the only moment a register other than the count or the pending flag may change
  always_ff @(posedge i_clk or posedge i_sys_rst)
    if (i_sys_rst)
      wr_dp_ff <= 1'b0;
    else
      wr_dp_ff <= take && i_hwrite;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  sequence read_wait_s;
    !o_hreadyout ##1 o_hreadyout;
  endsequence
  sequence quiet_src_s;
    !$rose(i_sub_clk) && !$rose(i_low_speed_oscillator_clk);
  endsequence
  read_wait_a: assert property (take && !i_hwrite |=> read_wait_s)
    else $error("read wait state wrong");
  write_nowait_a: assert property (take && i_hwrite |=> o_hreadyout)
    else $error("write data phase stalled");
  resp_okay_a: assert property (!o_hresp)
    else $error("response not okay");
  pulse_single_a: assert property (o_interval_timer_irq |=> !o_interval_timer_irq)
    else $error("request pulse too long");
  quiet_source_a: assert property (quiet_src_s [*8] |=> !o_interval_timer_irq)
    else $error("request without count clock");
  irq_rise_a: assert property ($rose(o_irq) |->
    o_interval_timer_irq || $past(o_interval_timer_irq) || wr_dp_ff || $past(wr_dp_ff))
    else $error("interrupt rose without cause");
  irq_fall_a: assert property ($fell(o_irq) |-> wr_dp_ff || $past(wr_dp_ff))
    else $error("interrupt fell without write");
  sub_clk_en_a: assert property (!i_standby [*4] |-> o_periph_sub_clk_en)
    else $error("peripheral clock cut while awake");
endmodule

bind itm_top itm_props itm_props_i (.*);

// ---- bench/testbench.sv ----
/*
  Self-checking bench for itm_top: AHB-Lite read and write tasks, count
  clocks made as slow pulses on the two source pins.
  Assumes one bus master; the slave's hreadyout is fed back as hready.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 1'b0, i_sys_rst = 1'b1, i_ce = 1'b1, i_hsel = 1'b0, i_hwrite = 1'b0;
  logic [31:0] i_haddr = 32'h0, i_hwdata = 32'h0, o_hrdata;
  logic [1:0] i_htrans = itm_pkg::HTRANS_IDLE;
  logic [2:0] i_hsize = itm_pkg::HSIZE_WORD;
  logic i_sub_clk = 1'b0, i_low_speed_oscillator_clk = 1'b0, i_standby = 1'b0;
  logic i_cpu_on_sub_clk = 1'b0, o_hreadyout, o_hresp, o_periph_sub_clk_en;
  logic o_interval_timer_irq, o_irq;
  wire logic i_hready;
  int fail_count = 0, samples_checked = 0, pulses = 0;
  assign i_hready = o_hreadyout;
  always #25 i_clk = ~i_clk;
  itm_top itm_top_i (.*);
  always @(negedge i_clk) pulses += (o_interval_timer_irq === 1'b1);

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      $display("unexpected %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask

  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge i_clk);
    i_hsel <= 1'b1;
    i_haddr <= {24'h0, a};
    i_htrans <= itm_pkg::HTRANS_NONSEQ;
    i_hwrite <= w;
    do @(posedge i_clk); while (o_hreadyout !== 1'b1);
    i_htrans <= itm_pkg::HTRANS_IDLE;
    i_hwdata <= wd;
    do @(posedge i_clk); while (o_hreadyout !== 1'b1);
    rd = o_hrdata;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task rd(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(n, e, x);
  endtask

  // Source pins toggle every 4 cycles, slower than the synchroniser needs
  task ticks(input logic lso, input int n);
    repeat (2 * n)
    begin
      repeat (4) @(posedge i_clk);
      if (lso)
        i_low_speed_oscillator_clk <= ~i_low_speed_oscillator_clk;
      else
        i_sub_clk <= ~i_sub_clk;
    end
    repeat (10) @(negedge i_clk);
  endtask

  task finish_test;
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    #1000000;
    fail_count++;
    finish_test();
  end

  initial
  begin
    repeat (6) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    rd("gates", itm_pkg::OFS_CLOCK_GATES, {24'h0, itm_pkg::RST_CLOCK_GATE, 7'h0});
    rd("flags", itm_pkg::OFS_IRQ_FLAGS, {29'h0, itm_pkg::RST_IRQ_PENDING, 2'h0});
    rd("masks", itm_pkg::OFS_IRQ_MASKS, {29'h0, itm_pkg::RST_IRQ_MASK, 2'h0});
    rd("control", itm_pkg::OFS_CONTROL,
      {16'h0, itm_pkg::RST_RUN, 3'h0, itm_pkg::RST_COMPARE});
    rd("clock cfg", itm_pkg::OFS_CLOCK_CFG, {24'h0, itm_pkg::RST_LOW_POWER_GATING, 2'h0,
      itm_pkg::RST_CLOCK_SELECT, 4'h0});
    rd("unmapped", 8'h40, 32'h0);
    $display("test reset values done");
    wr(itm_pkg::OFS_CLOCK_CFG, 32'h0);
    wr(itm_pkg::OFS_CONTROL, 32'h8003);
    ticks(1'b0, 6);
    rd("count gated", itm_pkg::OFS_COUNT, 32'h0);
    wr(itm_pkg::OFS_CLOCK_GATES, 32'h80);
    ticks(1'b0, 3);
    rd("count", itm_pkg::OFS_COUNT, 32'h3);
    ticks(1'b1, 3);
    rd("count unselected", itm_pkg::OFS_COUNT, 32'h3);
    ticks(1'b0, 1);
    rd("count wrap", itm_pkg::OFS_COUNT, 32'h0);
    rd("pending", itm_pkg::OFS_IRQ_FLAGS, 32'h4);
    chk("masked irq", 32'h0, {31'h0, o_irq});
    chk("pulses", 32'h1, pulses);
    $display("test count clock done");
    wr(itm_pkg::OFS_IRQ_FLAGS, 32'h4);
    rd("cleared", itm_pkg::OFS_IRQ_FLAGS, 32'h0);
    wr(itm_pkg::OFS_IRQ_MASKS, 32'h0);
    wr(itm_pkg::OFS_CLOCK_CFG, 32'h10);
    ticks(1'b1, 4);
    chk("irq", 32'h1, {31'h0, o_irq});
    chk("pulses", 32'h2, pulses);
    wr(itm_pkg::OFS_IRQ_MASKS, 32'h4);
    @(negedge i_clk);
    chk("irq masked", 32'h0, {31'h0, o_irq});
    wr(itm_pkg::OFS_IRQ_FLAGS, 32'h4);
    $display("test interrupt done");
    ticks(1'b1, 2);
    rd("count run", itm_pkg::OFS_COUNT, 32'h2);
    wr(itm_pkg::OFS_CONTROL, 32'h0003);
    rd("count stop", itm_pkg::OFS_COUNT, 32'h0);
    ticks(1'b1, 2);
    rd("count held", itm_pkg::OFS_COUNT, 32'h0);
    $display("test run control done");
    wr(itm_pkg::OFS_CONTROL, 32'h8003);
    wr(itm_pkg::OFS_CLOCK_CFG, 32'h80);
    i_standby <= 1'b1;
    i_cpu_on_sub_clk <= 1'b1;
    ticks(1'b0, 2);
    chk("periph clock", 32'h0, {31'h0, o_periph_sub_clk_en});
    rd("count standby", itm_pkg::OFS_COUNT, 32'h2);
    i_standby <= 1'b0;
    $display("test low power done");
    finish_test();
  end
endmodule

// ---- src/itm_counter.sv ----
/*
  The 12-bit interval counter with its compare match.
  Assumes a one-cycle tick per rising count clock edge from the tick generator.
*/
module itm_counter #(
  parameter int W = itm_pkg::CMP_W
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic i_tick,
  input wire logic i_run,
  input wire logic [W-1:0] i_compare,
  output logic [W-1:0] o_count,
  output logic o_match
);

  logic [W-1:0] count_ff;
  logic match_ff;

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      count_ff <= '0;
    end
    else if (i_ce)
    begin
      if (!i_run)
      begin
        count_ff <= '0;
      end
      else if (i_tick)
      begin
        // Period is compare plus one count clocks
        if (count_ff == i_compare)
        begin
          count_ff <= '0;
        end
        else
        begin
          count_ff <= count_ff + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      match_ff <= 1'b0;
    end
    else if (i_ce)
    begin
      match_ff <= i_run & i_tick & (count_ff == i_compare);
    end
  end

  assign o_count = count_ff;
  assign o_match = match_ff;

endmodule

// ---- src/itm_pkg.sv ----
/*
  Package for the 12-bit interval timer: register offsets, field positions,
  reset values and the bus-side enumerations.
  Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
*/
package itm_pkg;

  localparam int CMP_W = 12;
  localparam int ADDR_W = 8;

  // Byte offsets of the register words
  localparam logic [ADDR_W-1:0] OFS_CLOCK_GATES = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_IRQ_FLAGS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASKS = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_CLOCK_CFG = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h14;

  // Field positions
  localparam int BIT_CLOCK_GATE = 7;
  localparam int BIT_IRQ_PENDING = 2;
  localparam int BIT_IRQ_MASK = 2;
  localparam int BIT_RUN = 15;
  localparam int BIT_LOW_POWER_GATING = 7;
  localparam int BIT_CLOCK_SELECT = 4;

  // Reset values
  localparam logic RST_CLOCK_GATE = 1'b0;
  localparam logic RST_IRQ_PENDING = 1'b0;
  localparam logic RST_IRQ_MASK = 1'b1;
  localparam logic RST_RUN = 1'b0;
  localparam logic [CMP_W-1:0] RST_COMPARE = 12'hfff;
  localparam logic RST_LOW_POWER_GATING = 1'b0;
  localparam logic RST_CLOCK_SELECT = 1'b1;

  // AHB transfer types and the word transfer size
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef enum logic [1:0] {ITM_BUS_IDLE, ITM_BUS_RD_WAIT, ITM_BUS_WR_DATA} itm_bus_e;

endpackage

// ---- src/itm_tick_gen.sv ----
/*
  Count-tick generator: brings the subsystem clock and the low-speed
  oscillator clock into the system clock domain and turns their rising
  edges into one-cycle ticks, then selects one and gates it.
  Assumes both source clocks are well below half the system clock rate.
*/
module itm_tick_gen #(
  parameter int N_SRC = 2
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic [N_SRC-1:0] i_src_clk,
  input wire logic i_select,
  input wire logic i_gate,
  output logic o_tick
);

  logic [N_SRC-1:0] edge_tick;

  genvar g;
  generate
    for (g = 0; g < N_SRC; g++)
    begin : g_src
      logic meta_ff;
      logic sync_ff;
      logic prev_ff;
      always_ff @(posedge i_clk or posedge i_sys_rst)
      begin
        if (i_sys_rst)
        begin
          meta_ff <= 1'b0;
          sync_ff <= 1'b0;
          prev_ff <= 1'b0;
        end
        else if (i_ce)
        begin
          meta_ff <= i_src_clk[g];
          sync_ff <= meta_ff;
          prev_ff <= sync_ff;
        end
      end
      assign edge_tick[g] = sync_ff & ~prev_ff;
    end
  endgenerate

  // Select 0 is the subsystem clock, 1 the low-speed oscillator
  // Ticks reach the counter only while the clock gate is open
  assign o_tick = i_gate & i_ce & edge_tick[i_select];

endmodule

// ---- src/itm_top.sv ----
/*
  Top of the 12-bit interval timer: AHB-Lite register slave, interrupt
  flag and mask, count clock selection and the low-power clock supply.
  Assumes a single AHB-Lite master on i_clk; the subsystem and low-speed
  oscillator clocks arrive as asynchronous pins.
*/
// Local design decisions: the register offsets and the AHB-Lite register port.
module itm_top (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  input wire logic i_sub_clk,
  input wire logic i_low_speed_oscillator_clk,
  input wire logic i_standby,
  input wire logic i_cpu_on_sub_clk,
  output logic o_periph_sub_clk_en,
  output logic o_interval_timer_irq,
  output logic o_irq
);

  localparam int AW = itm_pkg::ADDR_W;
  localparam int CW = itm_pkg::CMP_W;

  itm_pkg::itm_bus_e bus_state_ff;
  logic [AW-1:0] addr_ff;
  logic [31:0] rdata_ff;
  logic interval_timer_clock_gate_ff;
  logic timer_irq_pending_ff;
  logic timer_irq_mask_ff;
  logic timer_run_ff;
  logic [CW-1:0] compare_value_ff;
  logic low_power_clock_gating_ff;
  logic count_clock_select_ff;
  logic sync_standby_meta_ff;
  logic sync_standby_ff;
  logic sync_cpu_sub_meta_ff;
  logic sync_cpu_sub_ff;
  logic [CW-1:0] count;
  logic match;
  logic tick;
  logic addr_phase;
  logic wr_strobe;
  logic [31:0] nxt_rdata;
  logic wr_gates;
  logic wr_flags;
  logic wr_masks;
  logic wr_control;
  logic wr_clock_cfg;
  logic periph_sub_clk_en_ff;

  assign addr_phase = i_ce & i_hsel & i_hready & (i_htrans == itm_pkg::HTRANS_NONSEQ);
  assign wr_strobe = i_ce & (bus_state_ff == itm_pkg::ITM_BUS_WR_DATA);
  assign wr_gates = wr_strobe & (addr_ff == itm_pkg::OFS_CLOCK_GATES);
  assign wr_flags = wr_strobe & (addr_ff == itm_pkg::OFS_IRQ_FLAGS);
  assign wr_masks = wr_strobe & (addr_ff == itm_pkg::OFS_IRQ_MASKS);
  assign wr_control = wr_strobe & (addr_ff == itm_pkg::OFS_CONTROL);
  assign wr_clock_cfg = wr_strobe & (addr_ff == itm_pkg::OFS_CLOCK_CFG);

  // Reads take one wait state so a write just before is already visible
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      bus_state_ff <= itm_pkg::ITM_BUS_IDLE;
      addr_ff <= '0;
    end
    else if (i_ce)
    begin
      unique case (bus_state_ff)
        itm_pkg::ITM_BUS_IDLE, itm_pkg::ITM_BUS_WR_DATA:
        begin
          if (addr_phase)
          begin
            addr_ff <= i_haddr[AW-1:0];
            bus_state_ff <= i_hwrite ? itm_pkg::ITM_BUS_WR_DATA : itm_pkg::ITM_BUS_RD_WAIT;
          end
          else
          begin
            bus_state_ff <= itm_pkg::ITM_BUS_IDLE;
          end
        end
        itm_pkg::ITM_BUS_RD_WAIT:
        begin
          bus_state_ff <= itm_pkg::ITM_BUS_IDLE;
        end
        // The fourth code of the state word is unused; recover to idle
        default:
        begin
          bus_state_ff <= itm_pkg::ITM_BUS_IDLE;
        end
      endcase
    end
  end

  assign o_hreadyout = (bus_state_ff != itm_pkg::ITM_BUS_RD_WAIT);
  assign o_hresp = 1'b0;

  always_comb
  begin
    nxt_rdata = '0;
    unique case (addr_ff)
      itm_pkg::OFS_CLOCK_GATES: nxt_rdata[itm_pkg::BIT_CLOCK_GATE] = interval_timer_clock_gate_ff;
      itm_pkg::OFS_IRQ_FLAGS: nxt_rdata[itm_pkg::BIT_IRQ_PENDING] = timer_irq_pending_ff;
      itm_pkg::OFS_IRQ_MASKS: nxt_rdata[itm_pkg::BIT_IRQ_MASK] = timer_irq_mask_ff;
      itm_pkg::OFS_CONTROL:
      begin
        nxt_rdata[itm_pkg::BIT_RUN] = timer_run_ff;
        nxt_rdata[CW-1:0] = compare_value_ff;
      end
      itm_pkg::OFS_CLOCK_CFG:
      begin
        nxt_rdata[itm_pkg::BIT_LOW_POWER_GATING] = low_power_clock_gating_ff;
        nxt_rdata[itm_pkg::BIT_CLOCK_SELECT] = count_clock_select_ff;
      end
      itm_pkg::OFS_COUNT: nxt_rdata[CW-1:0] = count;
      default: nxt_rdata = '0;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      rdata_ff <= '0;
    end
    else if (i_ce && bus_state_ff == itm_pkg::ITM_BUS_RD_WAIT)
    begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign o_hrdata = rdata_ff;

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      interval_timer_clock_gate_ff <= itm_pkg::RST_CLOCK_GATE;
    end
    else if (wr_gates)
    begin
      interval_timer_clock_gate_ff <= i_hwdata[itm_pkg::BIT_CLOCK_GATE];
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      timer_irq_mask_ff <= itm_pkg::RST_IRQ_MASK;
    end
    else if (wr_masks)
    begin
      timer_irq_mask_ff <= i_hwdata[itm_pkg::BIT_IRQ_MASK];
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      timer_run_ff <= itm_pkg::RST_RUN;
    end
    else if (wr_control)
    begin
      timer_run_ff <= i_hwdata[itm_pkg::BIT_RUN];
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      compare_value_ff <= itm_pkg::RST_COMPARE;
    end
    else if (wr_control)
    begin
      // A zero compare is not blocked; software must avoid it
      compare_value_ff <= i_hwdata[CW-1:0];
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      low_power_clock_gating_ff <= itm_pkg::RST_LOW_POWER_GATING;
      count_clock_select_ff <= itm_pkg::RST_CLOCK_SELECT;
    end
    else if (wr_clock_cfg)
    begin
      low_power_clock_gating_ff <= i_hwdata[itm_pkg::BIT_LOW_POWER_GATING];
      count_clock_select_ff <= i_hwdata[itm_pkg::BIT_CLOCK_SELECT];
    end
  end

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      timer_irq_pending_ff <= itm_pkg::RST_IRQ_PENDING;
    end
    else if (i_ce)
    begin
      if (match)
      begin
        timer_irq_pending_ff <= 1'b1;
      end
      else if (wr_flags && i_hwdata[itm_pkg::BIT_IRQ_PENDING])
      begin
        timer_irq_pending_ff <= 1'b0;
      end
    end
  end

  assign o_irq = timer_irq_pending_ff & ~timer_irq_mask_ff;
  assign o_interval_timer_irq = match;

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      sync_standby_meta_ff <= 1'b0;
      sync_standby_ff <= 1'b0;
      sync_cpu_sub_meta_ff <= 1'b0;
      sync_cpu_sub_ff <= 1'b0;
    end
    else if (i_ce)
    begin
      sync_standby_meta_ff <= i_standby;
      sync_standby_ff <= sync_standby_meta_ff;
      sync_cpu_sub_meta_ff <= i_cpu_on_sub_clk;
      sync_cpu_sub_ff <= sync_cpu_sub_meta_ff;
    end
  end

  // Only other peripherals lose the subsystem clock; the timer tick is
  // never gated by the low-power setting
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      periph_sub_clk_en_ff <= 1'b1;
    end
    else if (i_ce)
    begin
      periph_sub_clk_en_ff <= ~(sync_standby_ff & sync_cpu_sub_ff & low_power_clock_gating_ff);
    end
  end

  assign o_periph_sub_clk_en = periph_sub_clk_en_ff;

  itm_tick_gen #(
    .N_SRC(2)
  ) u_tick (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_ce(i_ce),
    .i_src_clk({i_low_speed_oscillator_clk, i_sub_clk}),
    .i_select(count_clock_select_ff),
    .i_gate(interval_timer_clock_gate_ff),
    .o_tick(tick)
  );

  itm_counter #(
    .W(CW)
  ) u_counter (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_ce(i_ce),
    .i_tick(tick),
    .i_run(timer_run_ff),
    .i_compare(compare_value_ff),
    .o_count(count),
    .o_match(match)
  );

endmodule
